// ==== shared/smrt_pkg.sv ====
// package for the static memory read timing engine
// assumes one clock domain, all control bits arrive as plain ports
package smrt_pkg;
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int OE_DLY_W = 4;
  localparam int RD_WAIT_W = 5;
  localparam int TURN_W = 4;
  localparam int EXT_WAIT_W = 14;
  localparam int CNT_W = 14;
  // internal ahb processing plus port arbitration ahead of the strobe phase
  localparam int ARB_CYCLES = 4;
  localparam logic [CNT_W-1:0] ARB_LOAD = 14'h0004;
  localparam logic [BANKS-1:0] SEL_IDLE = 4'hf;

  typedef enum logic [2:0] {
    SMRT_IDLE = 3'b000,
    SMRT_ARB = 3'b001,
    SMRT_TURN = 3'b010,
    SMRT_OEDLY = 3'b011,
    SMRT_WAIT = 3'b100,
    SMRT_DATA = 3'b101
  } smrt_state_t;

  typedef struct packed {
    logic [OE_DLY_W-1:0] oeDelayCycles;
    logic [RD_WAIT_W-1:0] readWaitStates;
    logic [TURN_W-1:0] turnaroundWaitStates;
    logic extendedWaitEnable;
  } smrt_bank_cfg_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } smrt_req_t;
endpackage

// ==== rtl/smrt_read_engine.sv ====
// read timing engine of the static memory controller
// assumes requests come from the ahb side on the same clock, read data pins are synchronous to it
// Behaviour
// - oe lags select by 0..15 cycles
// - oe drops with select at end
// - same read sequence for every bank type
// - select and address driven together first
// - read wait states lengthen access
// - turnaround idles between a write and the following read
// - zero wait read: T0-T4 arb, T5 data
// - two wait states give seven cycles
// - two oe delays give seven cycles
// - oe off two cycles, on third, capture
// - extended wait register replaces read delay
`timescale 1ns/10ps
module smrt_read_engine
  import smrt_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // per bank timing configuration, plus one extended wait count shared by all banks
  input wire smrt_bank_cfg_t bankCfg [BANKS],
  input wire logic [EXT_WAIT_W-1:0] extendedWaitStates,
  // request from the ahb side
  input wire logic reqValid,
  input wire smrt_req_t reqInfo,
  output logic reqReady,
  // notice that a write ran on the external bus
  input wire logic writeDone,
  input wire logic [BANK_W-1:0] writeBank,
  // read answer
  output logic rdValid,
  output logic [DATA_W-1:0] rdData,
  // external memory pins
  output logic [BANKS-1:0] bank_select_n,
  output logic [ADDR_W-1:0] ext_address_bus,
  output logic outputEnableN,
  input wire logic [DATA_W-1:0] extDataIn
);

  smrt_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  smrt_req_t req_r, req_nxt;
  logic lastWasWrite_r, lastWasWrite_nxt;
  logic [BANK_W-1:0] lastBank_r, lastBank_nxt;
  logic [BANKS-1:0] sel_r, sel_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic oeN_r, oeN_nxt;
  logic rdValid_r, rdValid_nxt;
  logic [DATA_W-1:0] rdData_r, rdData_nxt;
  smrt_bank_cfg_t cfg;
  logic [CNT_W-1:0] waitLoad;

  assign cfg = bankCfg[req_r.bank];
  // the bank type never enters the choice of timing
  assign waitLoad = cfg.extendedWaitEnable ? CNT_W'(extendedWaitStates)
                                           : CNT_W'(cfg.readWaitStates);
  // combinational, so a new read can be taken in the answer cycle
  assign reqReady = (state_r == SMRT_IDLE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    req_nxt = req_r;
    lastWasWrite_nxt = lastWasWrite_r;
    lastBank_nxt = lastBank_r;
    sel_nxt = sel_r;
    addr_nxt = addr_r;
    oeN_nxt = oeN_r;
    rdValid_nxt = 1'b0;
    rdData_nxt = rdData_r;
    if (writeDone) begin
      lastWasWrite_nxt = 1'b1;
      lastBank_nxt = writeBank;
    end
    unique case (state_r)
      SMRT_IDLE: begin
        if (reqValid) begin
          req_nxt = reqInfo;
          cnt_nxt = ARB_LOAD;
          state_nxt = SMRT_ARB;
        end
      end
      SMRT_ARB: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 14'h0001;
        end else if (lastWasWrite_r && bankCfg[lastBank_r].turnaroundWaitStates != '0) begin
          cnt_nxt = CNT_W'(bankCfg[lastBank_r].turnaroundWaitStates) - 14'h0001;
          state_nxt = SMRT_TURN;
        end else begin
          sel_nxt = ~(BANKS'(1) << req_r.bank);
          addr_nxt = req_r.addr;
          oeN_nxt = (cfg.oeDelayCycles != '0) ? 1'b1 : 1'b0;
          cnt_nxt = (cfg.oeDelayCycles != '0) ? CNT_W'(cfg.oeDelayCycles) - 14'h0001 : waitLoad;
          if (cfg.oeDelayCycles != '0) begin
            state_nxt = SMRT_OEDLY;
          end else if (waitLoad != '0) begin
            state_nxt = SMRT_WAIT;
          end else begin
            // nothing to wait for: the strobe cycle itself is the access
            state_nxt = SMRT_DATA;
          end
        end
      end
      SMRT_TURN: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 14'h0001;
        end else begin
          lastWasWrite_nxt = writeDone;
          sel_nxt = ~(BANKS'(1) << req_r.bank);
          addr_nxt = req_r.addr;
          oeN_nxt = (cfg.oeDelayCycles != '0);
          cnt_nxt = (cfg.oeDelayCycles != '0) ? CNT_W'(cfg.oeDelayCycles) - 14'h0001 : waitLoad;
          if (cfg.oeDelayCycles != '0) begin
            state_nxt = SMRT_OEDLY;
          end else if (waitLoad != '0) begin
            state_nxt = SMRT_WAIT;
          end else begin
            // same short cut as straight from arbitration
            state_nxt = SMRT_DATA;
          end
        end
      end
      SMRT_OEDLY: begin
        // select and address stay put, only the counter moves
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 14'h0001;
        end else begin
          oeN_nxt = 1'b0;
          // the oe delay stands in for the same number of wait states
          cnt_nxt = (waitLoad > CNT_W'(cfg.oeDelayCycles)) ? waitLoad - CNT_W'(cfg.oeDelayCycles) : '0;
          state_nxt = (cnt_nxt != '0) ? SMRT_WAIT : SMRT_DATA;
        end
      end
      SMRT_WAIT: begin
        oeN_nxt = 1'b0;
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 14'h0001;
        end
        if (cnt_r <= 14'h0001) begin
          state_nxt = SMRT_DATA;
        end
      end
      SMRT_DATA: begin
        rdData_nxt = extDataIn;
        rdValid_nxt = 1'b1;
        sel_nxt = SEL_IDLE;
        oeN_nxt = 1'b1;
        lastWasWrite_nxt = writeDone;
        lastBank_nxt = writeDone ? writeBank : req_r.bank;
        state_nxt = SMRT_IDLE;
      end
      default: state_nxt = SMRT_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= SMRT_IDLE;
      cnt_r <= '0;
      req_r <= '0;
      lastWasWrite_r <= 1'b0;
      lastBank_r <= '0;
      sel_r <= SEL_IDLE;
      addr_r <= '0;
      oeN_r <= 1'b1;
      rdValid_r <= 1'b0;
      rdData_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      req_r <= req_nxt;
      lastWasWrite_r <= lastWasWrite_nxt;
      lastBank_r <= lastBank_nxt;
      sel_r <= sel_nxt;
      addr_r <= addr_nxt;
      oeN_r <= oeN_nxt;
      rdValid_r <= rdValid_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign bank_select_n = sel_r;
  assign ext_address_bus = addr_r;
  assign outputEnableN = oeN_r;
  assign rdValid = rdValid_r;
  assign rdData = rdData_r;

  // checks
  logic selActive;
  int unsigned lat_r;
  assign selActive = (sel_r != SEL_IDLE);
  // cycles since the request was taken, cleared after the answer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lat_r <= 0;
    end else if (reqValid && reqReady) begin
      lat_r <= 1;
    end else if (lat_r != 0 && !rdValid_r) begin
      lat_r <= lat_r + 1;
    end else begin
      lat_r <= 0;
    end
  end

  oe_with_sel_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(bank_select_n == SEL_IDLE) |-> outputEnableN) else $error("oe still active after select dropped");
  oe_only_sel_a: assert property (@(posedge clock) disable iff (!resetn)
    !outputEnableN |-> selActive) else $error("oe active without select");
  sel_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    selActive && $past(selActive) |-> $stable(bank_select_n) && $stable(ext_address_bus))
    else $error("address or select moved during access");
  addr_sel_a: assert property (@(posedge clock) disable iff (!resetn)
    $fell(bank_select_n == SEL_IDLE) |-> ext_address_bus == req_r.addr) else $error("address not with select");
  oe_delay2_a: assert property (@(posedge clock) disable iff (!resetn)
    $fell(bank_select_n == SEL_IDLE) && cfg.oeDelayCycles == 4'h2 |-> outputEnableN [*2] ##1 !outputEnableN)
    else $error("oe delay of two not honoured");
  zero_wait_a: assert property (@(posedge clock) disable iff (!resetn)
    reqValid && reqReady && bankCfg[reqInfo.bank] == '0 && !lastWasWrite_r |-> ##7 rdValid)
    else $error("zero wait read not five cycles");
  two_wait_a: assert property (@(posedge clock) disable iff (!resetn)
    reqValid && reqReady && bankCfg[reqInfo.bank] == smrt_bank_cfg_t'{4'h0, 5'h02, 4'h0, 1'b0}
    && !lastWasWrite_r |-> ##9 rdValid) else $error("two wait read not seven cycles");
  oe_two_a: assert property (@(posedge clock) disable iff (!resetn)
    reqValid && reqReady && bankCfg[reqInfo.bank] == smrt_bank_cfg_t'{4'h2, 5'h02, 4'h0, 1'b0}
    && !lastWasWrite_r |-> ##9 rdValid) else $error("oe delay read not seven cycles");
  turn_gap_a: assert property (@(posedge clock) disable iff (!resetn)
    state_r == SMRT_TURN |-> bank_select_n == SEL_IDLE) else $error("select active in turnaround");
  ext_wait_a: assert property (@(posedge clock) disable iff (!resetn)
    $fell(bank_select_n == SEL_IDLE) && cfg.extendedWaitEnable && cfg.oeDelayCycles == '0
    |-> cnt_r == CNT_W'(extendedWaitStates)) else $error("extended wait not loaded");

  // every read pays the fixed ahb overhead, so nothing answers sooner
  lat_min_a: assert property (@(posedge clock) disable iff (!resetn)
    rdValid |-> lat_r >= 7)
    else $error("read answered too early");

  // the answer is a single pulse
  valid_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
    rdValid |=> !rdValid)
    else $error("read answer longer than one cycle");

  // read data only moves with its pulse
  data_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    !rdValid |-> $stable(rdData))
    else $error("read data moved without an answer");

  // oe may only be released together with the select
  oe_rise_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(outputEnableN) |-> bank_select_n == SEL_IDLE)
    else $error("oe released while select held");

  // a zero delay drives oe with the select, any other holds it back
  oe_first_a: assert property (@(posedge clock) disable iff (!resetn)
    $fell(bank_select_n == SEL_IDLE) |-> outputEnableN == (cfg.oeDelayCycles != '0))
    else $error("oe at select start does not match its delay");

  // during the delay phase oe stays off but the access is open
  oedly_oe_a: assert property (@(posedge clock) disable iff (!resetn)
    state_r == SMRT_OEDLY |-> outputEnableN && selActive)
    else $error("oe active during its delay");

  // never two banks at once on the shared pins
  one_bank_a: assert property (@(posedge clock) disable iff (!resetn)
    bank_select_n == SEL_IDLE || $onehot(~bank_select_n))
    else $error("more than one bank selected");

  // the select only starts out of arbitration or a turnaround
  sel_start_a: assert property (@(posedge clock) disable iff (!resetn)
    $fell(bank_select_n == SEL_IDLE) |-> $past(state_r == SMRT_ARB || state_r == SMRT_TURN))
    else $error("select started from the wrong phase");

  // data is taken while the memory still drives it
  capture_sel_a: assert property (@(posedge clock) disable iff (!resetn)
    rdValid |-> $past(selActive) && !$past(outputEnableN))
    else $error("data taken outside the strobe");

  // wait states run with the strobe fully on
  wait_oe_a: assert property (@(posedge clock) disable iff (!resetn)
    state_r == SMRT_WAIT |-> !outputEnableN && selActive)
    else $error("wait state without strobe");

  // an idle engine leaves the memory pins quiet
  idle_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
    reqReady |-> bank_select_n == SEL_IDLE && outputEnableN)
    else $error("pins active while idle");

  // a programmed turnaround is never skipped when a write is flagged as arbitration ends
  turn_entry_a: assert property (@(posedge clock) disable iff (!resetn)
    state_r == SMRT_ARB && cnt_r == '0 && lastWasWrite_r && bankCfg[lastBank_r].turnaroundWaitStates != '0
    |=> state_r == SMRT_TURN)
    else $error("turnaround skipped after a write");

  read_cov_c: cover property (@(posedge clock) disable iff (!resetn) rdValid);
  oedly_cov_c: cover property (@(posedge clock) disable iff (!resetn) state_r == SMRT_OEDLY ##1 state_r == SMRT_WAIT);
  turn_cov_c: cover property (@(posedge clock) disable iff (!resetn) state_r == SMRT_TURN ##1 state_r == SMRT_WAIT);
  ext_cov_c: cover property (@(posedge clock) disable iff (!resetn) state_r == SMRT_WAIT && cfg.extendedWaitEnable);
endmodule

// ==== dv/smrt_mem_model.sv ====
// external static memory seen through the read pins
// assumes data is wanted only while a select and oe are both low
`timescale 1ns/10ps
module smrt_mem_model
  import smrt_pkg::*;
(
  // memory pins
  input wire logic clock,
  input wire logic [BANKS-1:0] bank_select_n,
  input wire logic [ADDR_W-1:0] ext_address_bus,
  input wire logic outputEnableN,
  output logic [DATA_W-1:0] extDataIn
);
  logic [DATA_W-1:0] junk = 32'h0;
  // bus not driven: a pattern that flips every cycle, so early capture shows
  always @(posedge clock) junk <= ~junk ^ 32'h5a5a0000;
  // word is the address xored with the one-hot of the selected bank, so each bank answers its own word
  always_comb extDataIn = (!outputEnableN && !(&bank_select_n)) ?
    ({4'h0, ext_address_bus} ^ {28'h0, ~bank_select_n}) : junk;
endmodule

// ==== dv/static_memory_read_timing_tb_top.sv ====
// self-checking bench for the read timing engine
// assumes the timing walk of the hand-over: select at 5 plus turnaround
`timescale 1ns/10ps
module static_memory_read_timing_tb_top;
  import smrt_pkg::*;
  logic clock = 0;
  logic resetn = 0;
  smrt_bank_cfg_t bankCfg [BANKS];
  logic [EXT_WAIT_W-1:0] extendedWaitStates = '0;
  logic reqValid = 0;
  logic writeDone = 0;
  smrt_req_t reqInfo = '0;
  logic [BANK_W-1:0] writeBank = '0;
  logic reqReady, rdValid, outputEnableN;
  logic [DATA_W-1:0] rdData, extDataIn;
  logic [BANKS-1:0] bank_select_n;
  logic [ADDR_W-1:0] ext_address_bus;
  int bad_count = 0;
  int num_checks = 0;
  int prevWr = 0;
  int wrBank = 0;
  smrt_read_engine uut (.clock, .resetn, .bankCfg, .extendedWaitStates, .reqValid, .reqInfo, .reqReady,
    .writeDone, .writeBank, .rdValid, .rdData, .bank_select_n, .ext_address_bus, .outputEnableN, .extDataIn);
  smrt_mem_model mem (.clock, .bank_select_n, .ext_address_bus, .outputEnableN, .extDataIn);
  initial forever #2 clock = ~clock;
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one read, checked pin by pin every cycle until the answer
  task automatic do_read(int b, logic [ADDR_W-1:0] a);
    int w, oe, t, sel, lat;
    logic [3:0] m;
    logic on;
    m = ~(4'h1 << b);
    w = bankCfg[b].extendedWaitEnable ? extendedWaitStates : bankCfg[b].readWaitStates;
    oe = bankCfg[b].oeDelayCycles;
    t = prevWr ? bankCfg[wrBank].turnaroundWaitStates : 0;
    sel = 5 + t;
    lat = sel + 1 + (w > oe ? w : oe);
    reqValid = 1;
    reqInfo = '{b[BANK_W-1:0], a};
    chk("ready", reqReady, 1);
    for (int c = 0; c <= lat; c++) begin
      @(negedge clock);
      if (c == 0) reqValid = 0;
      on = c >= sel && c < lat;
      chk("select", bank_select_n, on ? m : 4'hf);
      chk("oe", outputEnableN, (c >= sel + oe && c < lat) ? 1'b0 : 1'b1);
      if (on) chk("addr", ext_address_bus, a);
      chk("valid", rdValid, c == lat);
      chk("busy", reqReady, c == lat);
      if (c == lat) chk("data", rdData, {4'h0, a} ^ (32'h1 << b));
    end
    prevWr = 0;
  endtask
  initial begin
    int dOe[5] = '{0, 0, 2, 2, 15};
    int dW[5] = '{0, 2, 2, 0, 3};
    foreach (bankCfg[i]) bankCfg[i] = '0;
    void'($urandom(32'h00562f5f));
    repeat (2) @(negedge clock);
    resetn = 1;
    // directed: plain, two waits, two oe delays, longest oe
    for (int i = 0; i < 5; i++) begin
      bankCfg[i % 4].oeDelayCycles = 4'(dOe[i]);
      bankCfg[i % 4].readWaitStates = 5'(dW[i]);
      do_read(i % 4, 28'($urandom));
    end
    for (int i = 0; i < 60; i++) begin
      foreach (bankCfg[k]) bankCfg[k] = 14'($urandom);
      extendedWaitStates = 14'($urandom_range(40));
      if ($urandom_range(2) == 0) begin
        writeBank = 2'($urandom);
        wrBank = writeBank;
        writeDone = 1;
        @(negedge clock);
        writeDone = 0;
        prevWr = 1;
      end
      do_read($urandom_range(3), 28'($urandom));
    end
    // long extended wait of 14'h3ff0, just short of the 14-bit maximum
    bankCfg[1].extendedWaitEnable = 1;
    extendedWaitStates = 14'h3ff0;
    do_read(1, 28'hfffffff);
    report_and_stop();
  end
endmodule
